// file: rtl/ptm_cap.sv
`timescale 1ns/10ps
module ptm_cap #(
    parameter int LEN = ptm_pkg::TRACE_LEN
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input ptm_pkg::ptm_j1_type rx_i,
    output logic [LEN*8-1:0] str_o,
    output logic done_o
);
    import ptm_pkg::*;

    localparam int POS_W = $clog2(LEN + 1);
    localparam logic [POS_W-1:0] POS_FULL = POS_W'(LEN);
    localparam logic [POS_W-1:0] POS_ONE = POS_W'(1);

    typedef struct packed {
        logic [POS_W-1:0] pos;
        logic [LEN*8-1:0] buffer;
        logic [LEN*8-1:0] str;
        logic done;
    } ptm_cap_state_type;

    ptm_cap_state_type st;
    ptm_cap_state_type next_st;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (rx_i.valid) begin
            // a start marker always restarts, so a torn string is dropped
            if (rx_i.first) begin
                next_st.buffer[7:0] = rx_i.data;
                next_st.pos = POS_ONE;
            end else if (st.pos != '0 && st.pos != POS_FULL) begin
                next_st.buffer[st.pos*8 +: 8] = rx_i.data;
                next_st.pos = st.pos + POS_ONE;
            end
            if (next_st.pos == POS_FULL && st.pos != POS_FULL) begin
                next_st.str = next_st.buffer;
                next_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign str_o = st.str;
    assign done_o = st.done;

endmodule

// file: rtl/ptm_pkg.sv
package ptm_pkg;

    // trace string geometry
    localparam int TRACE_LEN = 16;
    localparam int STR_W = TRACE_LEN * 8;
    localparam int STR_WORDS = TRACE_LEN / 4;
    localparam int IDX_W = $clog2(TRACE_LEN);

    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [3:0] RGN_TX = 4'h4;
    localparam logic [3:0] RGN_EXP = 4'h5;
    localparam logic [3:0] RGN_EXPV = 4'h6;
    localparam logic [3:0] RGN_RXV = 4'h7;

    // control fields
    localparam int CTRL_MODE = 0;
    localparam int CTRL_DIS_TIM = 2;
    localparam int CTRL_DIS_C2 = 3;
    localparam int CTRL_STS = 4;
    localparam int CTRL_MON = 5;
    localparam int CTRL_REREAD = 8;
    localparam int CTRL_DEFAULT = 9;

    // status fields
    localparam int STAT_TIM = 0;
    localparam int STAT_BASE_OK = 1;
    localparam int STAT_TX_CAP = 2;
    localparam int STAT_MODE = 4;

    // interrupt event bits
    localparam int IRQ_W = 3;
    localparam int EV_TIM_SET = 0;
    localparam int EV_TIM_CLR = 1;
    localparam int EV_RX_STR = 2;

    // reset values
    localparam logic [7:0] NULL_CHAR = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // periodic refresh of software-visible strings
    localparam int CLK_KHZ = 40_000;
    localparam int REFRESH_MS = 1000;
    localparam int REFRESH_CYC = CLK_KHZ * REFRESH_MS;

    typedef logic [STR_W-1:0] ptm_str_type;

    typedef enum logic [1:0] {
        PTM_OFF = 2'b00,
        PTM_AUTO = 2'b01,
        PTM_MANUAL = 2'b10
    } ptm_mode_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
    } ptm_av_req_type;

    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } ptm_j1_type;

endpackage

// file: rtl/ptm_top.sv
`timescale 1ns/10ps
// Overview of operation
// - The transmitter repeats the provisioned fixed-length string in J1.
// - An unprovisioned transmit string goes out as all null characters.
// - Trace transmit and compare work only when the path is STS level.
// - Auto mode latches the first complete received string as baseline.
// - Auto mode alarms when a received string differs from the baseline.
// - Manual mode uses the software-written expected string as baseline.
// - Manual mode alarms when a received string differs from that string.
// - An option suppresses AIS and RDI while the mismatch alarm is up.
// - Where fitted, an option suppresses AIS on a signal label mismatch.
// - Defaults are mode off with null transmit and expected strings.
// - In auto or manual mode at STS level visible strings refresh every second.
// - Software reads the last received string and can force a reread.
// - A receive-only build compares strings and, outside monitor mode, transmits only null characters.
// - A monitoring port checks the passing string and forwards it as is.
module ptm_top #(
    parameter bit TX_CAPABLE = 1'b1,
    parameter bit C2_OPTION = 1'b1,
    parameter int REFRESH_CYCLES = ptm_pkg::REFRESH_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input ptm_pkg::ptm_av_req_type av_i,
    output logic [31:0] av_readdata_o,
    output logic av_waitrequest_o,
    input ptm_pkg::ptm_j1_type rx_j1_i,
    input wire logic tx_req_i,
    output ptm_pkg::ptm_j1_type tx_j1_o,
    input wire logic c2_mismatch_i,
    output logic tim_o,
    output logic ais_suppress_o,
    output logic rdi_suppress_o,
    output logic irq_o
);
    import ptm_pkg::*;

    localparam logic [31:0] REFRESH_LAST = 32'(REFRESH_CYCLES - 1);
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(TRACE_LEN - 1);
    localparam logic [IDX_W-1:0] IDX_ONE = IDX_W'(1);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        ptm_mode_type mode;
        logic dis_tim;
        logic dis_c2;
        logic sts;
        logic mon;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        ptm_str_type tx_str;
        ptm_str_type exp_str;
        ptm_str_type base;
        logic base_ok;
        ptm_str_type last_rx;
        ptm_str_type exp_vis;
        ptm_str_type rx_vis;
        logic tim;
        logic [31:0] tick;
        logic [IDX_W-1:0] tx_idx;
        ptm_j1_type tx;
    } ptm_state_type;

    ptm_state_type st;
    ptm_state_type next_st;

    ptm_str_type cap_str;
    logic cap_done;

    ptm_cap #(
        .LEN(TRACE_LEN)
    ) u_cap (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .rx_i(rx_j1_i),
        .str_o(cap_str),
        .done_o(cap_done)
    );

    logic req_any;
    logic wr_go;
    logic [1:0] word_sel;
    logic [3:0] region;
    logic active;
    logic reread;
    logic refresh;
    ptm_str_type baseline;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;
    ptm_mode_type wr_mode;

    assign req_any = av_i.read | av_i.write;
    // a write lands only at the edge where waitrequest is low
    assign wr_go = av_i.write & st.ack;
    assign word_sel = av_i.address[3:2];
    assign region = av_i.address[7:4];

    assign active = (st.mode != PTM_OFF) && st.sts;

    assign baseline = (st.mode == PTM_MANUAL) ? st.exp_str : st.base;

    always_comb begin
        unique case (av_i.writedata[CTRL_MODE +: 2])
            2'b01: wr_mode = PTM_AUTO;
            2'b10: wr_mode = PTM_MANUAL;
            default: wr_mode = PTM_OFF;
        endcase
    end

    always_comb begin
        next_st = st;
        reread = 1'b0;
        ev = '0;
        w1c = '0;

        // single wait state: request seen, answer on the next edge
        next_st.ack = req_any & ~st.ack;

        // read data is prepared while waitrequest is still high
        if (av_i.read & ~st.ack) begin
            next_st.rdata = 32'h0;
            if (av_i.address == OFF_CTRL) begin
                next_st.rdata[CTRL_MODE +: 2] = st.mode;
                next_st.rdata[CTRL_DIS_TIM] = st.dis_tim;
                next_st.rdata[CTRL_DIS_C2] = st.dis_c2;
                next_st.rdata[CTRL_STS] = st.sts;
                next_st.rdata[CTRL_MON] = st.mon;
            end else if (av_i.address == OFF_STATUS) begin
                next_st.rdata[STAT_TIM] = st.tim;
                next_st.rdata[STAT_BASE_OK] = st.base_ok;
                next_st.rdata[STAT_TX_CAP] = TX_CAPABLE;
                next_st.rdata[STAT_MODE +: 2] = st.mode;
            end else if (av_i.address == OFF_IRQ_STAT) begin
                next_st.rdata[IRQ_W-1:0] = st.irq_stat;
            end else if (av_i.address == OFF_IRQ_MASK) begin
                next_st.rdata[IRQ_W-1:0] = st.irq_mask;
            end else if (region == RGN_TX) begin
                next_st.rdata = st.tx_str[word_sel*32 +: 32];
            end else if (region == RGN_EXP) begin
                next_st.rdata = st.exp_str[word_sel*32 +: 32];
            end else if (region == RGN_EXPV) begin
                next_st.rdata = st.exp_vis[word_sel*32 +: 32];
            end else if (region == RGN_RXV) begin
                next_st.rdata = st.rx_vis[word_sel*32 +: 32];
            end
        end

        if (wr_go) begin
            if (av_i.address == OFF_CTRL) begin
                // a mode change forgets any learned baseline
                if (wr_mode != st.mode) begin
                    next_st.base_ok = 1'b0;
                end
                next_st.mode = wr_mode;
                next_st.dis_tim = av_i.writedata[CTRL_DIS_TIM];
                next_st.dis_c2 = av_i.writedata[CTRL_DIS_C2] & C2_OPTION;
                next_st.sts = av_i.writedata[CTRL_STS];
                next_st.mon = av_i.writedata[CTRL_MON];
                reread = av_i.writedata[CTRL_REREAD];
                if (av_i.writedata[CTRL_DEFAULT]) begin
                    next_st.mode = PTM_OFF;
                    next_st.tx_str = {TRACE_LEN{NULL_CHAR}};
                    next_st.exp_str = {TRACE_LEN{NULL_CHAR}};
                    next_st.base_ok = 1'b0;
                end
            end else if (av_i.address == OFF_IRQ_STAT) begin
                w1c = av_i.writedata[IRQ_W-1:0];
            end else if (av_i.address == OFF_IRQ_MASK) begin
                next_st.irq_mask = av_i.writedata[IRQ_W-1:0];
            end else if (region == RGN_TX) begin
                next_st.tx_str[word_sel*32 +: 32] = av_i.writedata;
            end else if (region == RGN_EXP) begin
                next_st.exp_str[word_sel*32 +: 32] = av_i.writedata;
            end
        end

        // compare runs on the state before this cycle's write
        if (cap_done) begin
            next_st.last_rx = cap_str;
            if (active) begin
                if (st.mode == PTM_AUTO && !st.base_ok) begin
                    next_st.base = cap_str;
                    next_st.base_ok = 1'b1;
                    next_st.tim = 1'b0;
                end else begin
                    next_st.tim = (cap_str != baseline);
                end
            end
        end

        if (!active) begin
            next_st.tim = 1'b0;
        end
        if (st.mode == PTM_OFF) begin
            next_st.base_ok = 1'b0;
        end

        if (st.tick >= REFRESH_LAST) begin
            next_st.tick = 32'h0;
        end else begin
            next_st.tick = st.tick + 32'h1;
        end
        refresh = (st.tick >= REFRESH_LAST) && active;
        if (refresh || reread) begin
            next_st.rx_vis = st.last_rx;
            if (st.mode == PTM_MANUAL) begin
                next_st.exp_vis = st.exp_str;
            end else if (st.base_ok) begin
                next_st.exp_vis = st.base;
            end else begin
                next_st.exp_vis = {TRACE_LEN{NULL_CHAR}};
            end
        end

        // sticky events: a set in the clearing cycle survives
        ev[EV_TIM_SET] = next_st.tim & ~st.tim;
        ev[EV_TIM_CLR] = st.tim & ~next_st.tim;
        ev[EV_RX_STR] = cap_done & active;
        next_st.irq_stat = (st.irq_stat & ~w1c) | ev;

        // transmit byte stream
        next_st.tx.valid = 1'b0;
        next_st.tx.first = 1'b0;
        if (st.mon) begin
            next_st.tx = rx_j1_i;
        end else if (tx_req_i) begin
            next_st.tx.valid = 1'b1;
            next_st.tx.first = (st.tx_idx == '0);
            if (TX_CAPABLE && st.sts) begin
                next_st.tx.data = st.tx_str[st.tx_idx*8 +: 8];
            end else begin
                next_st.tx.data = NULL_CHAR;
            end
            if (st.tx_idx == IDX_LAST) begin
                next_st.tx_idx = '0;
            end else begin
                next_st.tx_idx = st.tx_idx + IDX_ONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign av_waitrequest_o = req_any & ~st.ack;
    assign av_readdata_o = st.rdata;
    assign tx_j1_o = st.tx;
    assign tim_o = st.tim;
    assign ais_suppress_o = (st.tim & st.dis_tim) | (c2_mismatch_i & st.dis_c2);
    assign rdi_suppress_o = st.tim & st.dis_tim;
    assign irq_o = |(st.irq_stat & st.irq_mask);

endmodule

// file: test/ptm_far.sv
`timescale 1ns/10ps
module ptm_far (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [7:0] seed_i,
    input wire logic slow_i,
    output ptm_pkg::ptm_j1_type j1_o,
    output logic busy_o
);
    import ptm_pkg::*;
    logic [4:0] cnt = 5'h10;
    logic gap = 1'b0;
    initial j1_o = '0;
    always @(posedge clk_i) begin
        // idle data flips so a stale byte never looks valid
        j1_o <= {2'b00, ~j1_o.data};
        gap <= slow_i & ~gap;
        if (go_i) begin
            cnt <= 5'h00;
        end else if (cnt < 5'h10 && !gap) begin
            j1_o <= {1'b1, cnt == 5'h00, seed_i + {3'h0, cnt}};
            cnt <= cnt + 5'h01;
        end
    end
    assign busy_o = go_i | (cnt < 5'h10);
endmodule

// file: test/ptm_props.sv
`timescale 1ns/10ps
module ptm_props (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input ptm_pkg::ptm_av_req_type av_i,
    input wire logic [31:0] av_readdata_o,
    input wire logic av_waitrequest_o,
    input ptm_pkg::ptm_j1_type rx_j1_i,
    input wire logic tx_req_i,
    input ptm_pkg::ptm_j1_type tx_j1_o,
    input wire logic c2_mismatch_i,
    input wire logic tim_o,
    input wire logic ais_suppress_o,
    input wire logic rdi_suppress_o
);
    import ptm_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_req;
        $rose(av_i.read | av_i.write);
    endsequence
    sequence s_ans;
        av_waitrequest_o ##1 !av_waitrequest_o;
    endsequence
    property p_bus;
        s_req |-> s_ans;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus answer late");
    property p_rdata;
        $changed(av_readdata_o) |-> $past(av_i.read);
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data moved");
    property p_tx_valid;
        tx_j1_o.valid |-> $past(tx_req_i) || $past(rx_j1_i.valid);
    endproperty
    a_tx_valid: assert property (p_tx_valid)
        else $error("unrequested byte");
    property p_tx_first;
        tx_j1_o.first |-> tx_j1_o.valid;
    endproperty
    a_tx_first: assert property (p_tx_first)
        else $error("start without byte");
    property p_rdi;
        rdi_suppress_o |-> tim_o && ais_suppress_o;
    endproperty
    a_rdi: assert property (p_rdi)
        else $error("rdi held without alarm");
    property p_ais;
        ais_suppress_o != rdi_suppress_o |-> c2_mismatch_i && ais_suppress_o;
    endproperty
    a_ais: assert property (p_ais)
        else $error("ais without cause");
    // alarm set only by a complete string, cleared by one or by a write
    property p_tim_rise;
        $rose(tim_o) |-> $past(rx_j1_i.valid, 2);
    endproperty
    a_tim_rise: assert property (p_tim_rise)
        else $error("alarm rose without string");
    property p_tim_fall;
        $fell(tim_o) |-> $past(rx_j1_i.valid, 2) || $past(av_i.write)
            || $past(av_i.write, 2);
    endproperty
    a_tim_fall: assert property (p_tim_fall)
        else $error("alarm fell without cause");
endmodule

// file: test/ptm_top_tb.sv
`timescale 1ns/10ps
module ptm_top_tb;
    import ptm_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    ptm_av_req_type av = '0;
    logic [31:0] rdata;
    logic av_wait;
    logic tx_req = 1'b0;
    logic c2_mm = 1'b0;
    ptm_j1_type rx;
    ptm_j1_type tx;
    logic tim, ais, rdi, irq, busy;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic [7:0] seed = 8'h00;
    logic [31:0] q;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    ptm_top #(.REFRESH_CYCLES(64)) dut_u (.clk_i(clk), .rst_b_i(rst_b),
        .av_i(av), .av_readdata_o(rdata), .av_waitrequest_o(av_wait),
        .rx_j1_i(rx), .tx_req_i(tx_req), .tx_j1_o(tx),
        .c2_mismatch_i(c2_mm), .tim_o(tim), .ais_suppress_o(ais),
        .rdi_suppress_o(rdi), .irq_o(irq));

    ptm_far far_u (.clk_i(clk), .go_i(go), .seed_i(seed),
        .slow_i(slow), .j1_o(rx), .busy_o(busy));

    task automatic final_report();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic bit_chk(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask

    // waitrequest and read data are taken at the same rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        logic w;
        int n;
        w = 1'b1;
        n = 0;
        av <= '{~wr, wr, a, d};
        while (w !== 1'b0 && n < 20) begin
            @(posedge clk);
            w = av_wait;
            q = rdata;
            n++;
        end
        if (w !== 1'b0) begin
            failures++;
            $display("ERROR %0t bus hang", $time);
        end
        av <= '0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    function automatic logic [31:0] wd(input logic [7:0] s, input int k);
        logic [7:0] b;
        b = s + 8'(4 * k);
        return {b + 8'h3, b + 8'h2, b + 8'h1, b};
    endfunction

    task automatic wstr(input logic [3:0] r, input logic [7:0] s);
        for (int k = 0; k < 4; k++) bus(1'b1, {r, 4'(4 * k)}, wd(s, k));
    endtask

    task automatic tx_chk(input logic [7:0] s, input logic nul);
        for (int i = 0; i < 32; i++) begin
            tx_req <= 1'b1;
            @(posedge clk);
            tx_req <= 1'b0;
            @(negedge clk);
            chk({tx.valid, tx.data}, {1'b1, nul ? 8'h0 : s + 8'(i % 16)});
            if (!nul) bit_chk(tx.first, i % 16 == 0);
            @(posedge clk);
        end
    endtask

    // fixed tail: alarm settles two edges after the last byte
    task automatic send(input logic [7:0] s, input logic sl);
        int n;
        n = 0;
        seed <= s;
        slow <= sl;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (busy === 1'b1 && n < 80);
        if (busy !== 1'b0) begin
            failures++;
            $display("ERROR %0t far end hang", $time);
        end
        repeat (5) @(posedge clk);
    endtask

    task automatic t_defaults();
        rd(OFF_CTRL, 32'h0);
        rd(OFF_STATUS, 32'h4);
        rd({RGN_EXPV, 4'h0}, 32'h0);
        rd(OFF_IRQ_MASK, 32'h0);
        rd(8'h30, 32'h0);
        $display("defaults done");
    endtask

    task automatic t_tx();
        bus(1'b1, OFF_CTRL, 32'h10);
        tx_chk(8'h00, 1'b1);
        wstr(RGN_TX, 8'h30);
        tx_chk(8'h30, 1'b0);
        bus(1'b1, OFF_CTRL, 32'h0);
        tx_chk(8'h00, 1'b1);
        $display("transmit done");
    endtask

    task automatic t_auto();
        bus(1'b1, OFF_IRQ_MASK, 32'h1);
        bus(1'b1, OFF_CTRL, 32'h15);
        send(8'h41, 1'b1);
        bit_chk(tim, 1'b0);
        rd(OFF_STATUS, 32'h16);
        send(8'h61, 1'b0);
        bit_chk(tim, 1'b1);
        bit_chk(rdi, 1'b1);
        bit_chk(ais, 1'b1);
        bit_chk(irq, 1'b1);
        bus(1'b1, OFF_IRQ_STAT, 32'h1);
        bit_chk(irq, 1'b0);
        repeat (70) @(posedge clk);
        rd({RGN_RXV, 4'h0}, wd(8'h61, 0));
        rd({RGN_EXPV, 4'hC}, wd(8'h41, 3));
        send(8'h41, 1'b0);
        bit_chk(tim, 1'b0);
        rd(OFF_IRQ_STAT, 32'h6);
        $display("auto done");
    endtask

    task automatic t_manual();
        wstr(RGN_EXP, 8'h61);
        bus(1'b1, OFF_CTRL, 32'h1A);
        send(8'h41, 1'b0);
        bit_chk(tim, 1'b1);
        bit_chk(rdi, 1'b0);
        c2_mm <= 1'b1;
        @(posedge clk);
        bit_chk(ais, 1'b1);
        c2_mm <= 1'b0;
        @(posedge clk);
        bit_chk(ais, 1'b0);
        send(8'h61, 1'b0);
        bit_chk(tim, 1'b0);
        bus(1'b1, OFF_CTRL, 32'h11A);
        rd({RGN_RXV, 4'h4}, wd(8'h61, 1));
        $display("manual done");
    endtask

    // the framer keeps asking, but monitor mode must forward the link only
    task automatic t_mon();
        ptm_j1_type p;
        int v;
        v = 0;
        bus(1'b1, OFF_CTRL, 32'h30);
        seed <= 8'h51;
        slow <= 1'b0;
        go <= 1'b1;
        tx_req <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        p = rx;
        repeat (24) begin
            @(negedge clk);
            chk({22'h0, tx}, {22'h0, p});
            v += int'(tx.valid);
            p = rx;
        end
        chk(v, 16);
        @(posedge clk);
        tx_req <= 1'b0;
        $display("monitor done");
    endtask

    task automatic t_off();
        bus(1'b1, OFF_CTRL, 32'h12);
        send(8'h41, 1'b0);
        bit_chk(tim, 1'b1);
        bus(1'b1, OFF_CTRL, 32'h10);
        send(8'h41, 1'b0);
        bit_chk(tim, 1'b0);
        bus(1'b1, OFF_CTRL, 32'h200);
        rd(OFF_CTRL, 32'h0);
        rd({RGN_EXP, 4'h0}, 32'h0);
        bus(1'b1, OFF_CTRL, 32'h10);
        tx_chk(8'h00, 1'b1);
        $display("off done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_defaults();
        t_tx();
        t_auto();
        t_manual();
        t_mon();
        t_off();
        final_report();
    end
endmodule

bind ptm_top ptm_props props_u (.clk_i, .rst_b_i, .av_i, .av_readdata_o,
    .av_waitrequest_o, .rx_j1_i, .tx_req_i, .tx_j1_o, .c2_mismatch_i,
    .tim_o, .ais_suppress_o, .rdi_suppress_o);
